// >>> itt_pkg.sv
package itt_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int MS_PER_S = 1000;
	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] A_SWITCH = 8'h00;
	localparam logic [ADDR_W-1:0] A_PH_SET = 8'h04;
	localparam logic [ADDR_W-1:0] A_RES_SET = 8'h08;
	localparam logic [ADDR_W-1:0] A_PH_K = 8'h0c;
	localparam logic [ADDR_W-1:0] A_RES_K = 8'h10;
	localparam logic [ADDR_W-1:0] A_PH_DEF = 8'h14;
	localparam logic [ADDR_W-1:0] A_RES_DEF = 8'h18;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h1c;
	localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h20;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h24;
	localparam logic [ADDR_W-1:0] A_PH_TIME = 8'h28;
	localparam logic [ADDR_W-1:0] A_RES_TIME = 8'h2c;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int PH_MODE_LSB = 0;
	localparam int RES_MODE_LSB = 5;
	localparam int SW_W = 8;

	typedef enum logic [2:0]
	{
		M_DEF = 3'h0,
		M_EXT = 3'h1,
		M_VERY = 3'h2,
		M_NORM = 3'h3,
		M_LONG = 3'h4,
		M_MECH = 3'h5,
		M_LOG = 3'h6
	} itt_mode_t;

	typedef enum logic [2:0]
	{
		ST_RGO = 3'b000,
		ST_RWAIT = 3'b001,
		ST_TGO = 3'b011,
		ST_TWAIT = 3'b010,
		ST_STORE = 3'b110
	} itt_state_t;

	typedef struct packed
	{
		logic [15:0] set;
		logic [15:0] k;
		logic [31:0] def_ms;
	} itt_cfg_t;

	typedef struct packed
	{
		logic start;
		logic operate;
	} itt_ind_t;

	localparam logic [15:0] RST_SET = 16'h0100;
	localparam logic [15:0] RST_K = 16'h03e8;
	localparam logic [31:0] RST_DEF = 32'h0000_0064;

	// ratios are q8.8, curve terms q.12, times in ms, k in thousandths
	localparam int Q8 = 8;
	localparam int Q12 = 12;
	localparam int Q8_TO_Q12 = 4;
	localparam int HALF_SQ_SH = 13;
	localparam int SQ_TO_Q12 = 4;
	localparam longint ONE_Q8 = 64'h100;
	localparam longint ONE_Q12 = 64'h1000;
	localparam longint K_SCALE = 64'h3e8;
	localparam logic [31:0] THR_STD = 32'h14d;
	localparam logic [31:0] THR_LONG = 32'h11a;
	localparam logic [31:0] THR_UNITY = 32'h100;
	localparam longint NI_ALPHA = 64'h52;
	localparam longint NI_BETA = 64'h23d;
	localparam longint VI_BETA = 64'hd800;
	localparam longint EI_BETA = 64'h5_0000;
	localparam longint LI_BETA = 64'h7_8000;
	localparam longint MECH_A = 64'h56d;
	localparam longint MECH_B = 64'h3c7;
	localparam longint LOG_BASE_MS = 64'h16a8;
	localparam longint LOG_SLOPE_MS = 64'h546;
	localparam longint LN2_Q12 = 64'hb17;
	localparam longint LOG_CORR_MUL = 64'hb;
	localparam int LOG_CORR_SH = 5;
	localparam int LOG_MSB = 15;
	localparam int LOG_DROP = 3;
	localparam longint FRAC_MASK = 64'hfff;
	localparam logic [31:0] PATH_DELAY_MS = 32'h1e;
endpackage

// >>> itt_div.sv
module itt_div
	import itt_pkg::*;
#(
	parameter int W = 40
)
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         go,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	output logic              done,
	output logic [W-1:0]      quo
);
	// restoring divider, one quotient bit per clock; divide by zero gives all ones
	logic [W:0]          rem_q;
	logic [W-1:0]        den_q;
	logic [$clog2(W):0]  cnt_q;
	logic                busy_q;
	logic [W:0]          trial;

	if (W < 2)
	begin : g_chk
		$error("itt_div width too small");
	end

	assign trial = {rem_q[W-1:0], quo[W-1]} - {1'b0, den_q};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rem_q <= '0;
			den_q <= '0;
			quo <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (go)
			begin
				rem_q <= '0;
				den_q <= den;
				quo <= num;
				cnt_q <= ($clog2(W)+1)'(W);
				busy_q <= 1'b1;
			end
			else if (busy_q)
			begin
				if (!trial[W])
					rem_q <= trial;
				else
					rem_q <= {rem_q[W-1:0], quo[W-1]};
				quo <= {quo[W-2:0], ~trial[W]};
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == ($clog2(W)+1)'(1))
				begin
					busy_q <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> itt_top.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
module itt_top
	import itt_pkg::*;
#(
	parameter int MS_CYCLES = CLK_HZ / MS_PER_S
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [15:0]       ph_current,
	input  wire logic [15:0]       res_current,
	output logic                   ph_start,
	output logic                   ph_operate,
	output logic                   res_start,
	output logic                   res_operate,
	output logic                   irq
);
	localparam int DW = 40;

	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              do_write;
	logic [31:0]       rd_word;
	logic [SW_W-1:0]   function_switch_group_q;
	itt_cfg_t          cfg_q [2];
	logic [3:0]        irq_st_q;
	logic [3:0]        irq_mask_q;
	logic [3:0]        irq_clr;
	logic [3:0]        ev;
	logic [31:0]       tick_cnt_q;
	logic              tick_q;
	itt_ind_t          ind_q [2];
	logic [1:0]        st_raw;
	logic [31:0]       elapsed_q [2];
	logic [31:0]       tgt_q [2];
	itt_state_t        st_q;
	logic              stg_q;
	logic              div_go_q;
	logic [DW-1:0]     num_q;
	logic [DW-1:0]     den_q;
	logic              div_done;
	logic [DW-1:0]     div_quo;
	logic [15:0]       ratio_q;
	logic [31:0]       t_new_q;
	itt_mode_t         md;
	logic              c_direct;
	logic [31:0]       c_time;
	logic [DW-1:0]     c_num;
	logic [DW-1:0]     c_den;
	longint            lm;
	longint            x;
	longint            d;
	longint            n;
	logic [15:0]       cur [2];

	if (MS_CYCLES < 1)
	begin : g_chk
		$error("MS_CYCLES must be at least one");
	end

	assign cur[0] = ph_current;
	assign cur[1] = res_current;

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		return a <= A_RES_TIME && a[1:0] == 2'h0;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = v[b*8 +: 8];
		return r;
	endfunction

	function automatic itt_mode_t mode_of(input logic [2:0] f);
		// the spare code falls back to definite time
		return (f == 3'h7) ? M_DEF : itt_mode_t'(f);
	endfunction

	function automatic logic [31:0] thr_of(input itt_mode_t m);
		unique case (m)
			M_EXT, M_VERY, M_NORM: return THR_STD;
			M_LONG: return THR_LONG;
			default: return THR_UNITY;
		endcase
	endfunction

	// ln in q.12 from a q8.8 value: leading one plus a parabolic mantissa fix,
	// good to well under 1%, which keeps the curves inside class 5
	function automatic longint ln_q12(input logic [15:0] v);
		longint p;
		longint f;
		longint l2;
		p = 0;
		for (int i = 0; i < 16; i++)
			if (v[i])
				p = i;
		f = ((longint'(v) << (LOG_MSB - p)) >> LOG_DROP) & FRAC_MASK;
		l2 = ((p - Q8) <<< Q12) + f
			+ ((((f * (ONE_Q12 - f)) >>> Q12) * LOG_CORR_MUL) >>> LOG_CORR_SH);
		return (l2 * LN2_Q12) >>> Q12;
	endfunction

	// write path: address and data taken in either order, then one response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_addr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			function_switch_group_q <= '0;
			irq_mask_q <= '0;
			for (int s = 0; s < 2; s++)
				cfg_q[s] <= '{set: RST_SET, k: RST_K, def_ms: RST_DEF};
		end
		else if (do_write)
		begin
			unique case (aw_addr_q)
				A_SWITCH: function_switch_group_q <= SW_W'(merge(32'(function_switch_group_q),
					wdata_q, wstrb_q));
				A_PH_SET: cfg_q[0].set <= 16'(merge(32'(cfg_q[0].set), wdata_q, wstrb_q));
				A_RES_SET: cfg_q[1].set <= 16'(merge(32'(cfg_q[1].set), wdata_q, wstrb_q));
				A_PH_K: cfg_q[0].k <= 16'(merge(32'(cfg_q[0].k), wdata_q, wstrb_q));
				A_RES_K: cfg_q[1].k <= 16'(merge(32'(cfg_q[1].k), wdata_q, wstrb_q));
				A_PH_DEF: cfg_q[0].def_ms <= merge(cfg_q[0].def_ms, wdata_q, wstrb_q);
				A_RES_DEF: cfg_q[1].def_ms <= merge(cfg_q[1].def_ms, wdata_q, wstrb_q);
				A_IRQ_MASK: irq_mask_q <= 4'(merge(32'(irq_mask_q), wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	// new events win over a one-written clear in the same cycle
	assign irq_clr = (do_write && aw_addr_q == A_IRQ_ST && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_st_q <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irq_st_q <= (irq_st_q & ~irq_clr) | ev;
			irq <= |(irq_st_q & irq_mask_q);
		end
	end

	always_comb
	begin
		unique case (s_axi_araddr)
			A_SWITCH: rd_word = 32'(function_switch_group_q);
			A_PH_SET: rd_word = 32'(cfg_q[0].set);
			A_RES_SET: rd_word = 32'(cfg_q[1].set);
			A_PH_K: rd_word = 32'(cfg_q[0].k);
			A_RES_K: rd_word = 32'(cfg_q[1].k);
			A_PH_DEF: rd_word = cfg_q[0].def_ms;
			A_RES_DEF: rd_word = cfg_q[1].def_ms;
			A_STATUS: rd_word = 32'({ind_q[1], ind_q[0]});
			A_IRQ_ST: rd_word = 32'(irq_st_q);
			A_IRQ_MASK: rd_word = 32'(irq_mask_q);
			A_PH_TIME: rd_word = tgt_q[0];
			A_RES_TIME: rd_word = tgt_q[1];
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// one millisecond enable for the elapsed-time counters
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= tick_cnt_q == 32'(MS_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == 32'(MS_CYCLES - 1)) ? '0 : tick_cnt_q + 1'b1;
		end
	end

	// curve evaluation for the stage now in the engine
	assign md = mode_of(stg_q ? function_switch_group_q[RES_MODE_LSB +: 3]
		: function_switch_group_q[PH_MODE_LSB +: 3]);

	always_comb
	begin
		lm = ln_q12(ratio_q);
		x = 0;
		d = 1;
		n = 0;
		c_direct = 1'b0;
		c_time = 32'h0;
		unique case (md)
			M_NORM:
			begin
				x = (lm * NI_ALPHA) >>> Q12;
				d = x + ((x * x) >>> HALF_SQ_SH);
				n = longint'(cfg_q[stg_q].k) * NI_BETA;
			end
			M_VERY:
			begin
				d = (longint'(ratio_q) - ONE_Q8) <<< Q8_TO_Q12;
				n = longint'(cfg_q[stg_q].k) * VI_BETA;
			end
			M_LONG:
			begin
				d = (longint'(ratio_q) - ONE_Q8) <<< Q8_TO_Q12;
				n = longint'(cfg_q[stg_q].k) * LI_BETA;
			end
			M_EXT:
			begin
				d = ((longint'(ratio_q) * longint'(ratio_q)) >>> SQ_TO_Q12) - ONE_Q12;
				n = longint'(cfg_q[stg_q].k) * EI_BETA;
			end
			M_MECH:
			begin
				d = ((longint'(ratio_q) * MECH_A) >>> Q8) - MECH_B;
				n = (longint'(cfg_q[stg_q].k) * longint'(ratio_q)) <<< Q8_TO_Q12;
			end
			M_LOG:
			begin
				c_direct = 1'b1;
				x = LOG_BASE_MS - ((LOG_SLOPE_MS * lm) >>> Q12);
				c_time = (x < 0) ? 32'h0 : 32'(x);
			end
			default:
			begin
				c_direct = 1'b1;
				c_time = cfg_q[stg_q].def_ms;
			end
		endcase
		// a flat or negative divisor gives the all-ones time, so operate waits until the elapsed count saturates
		if (!c_direct && d <= 0)
		begin
			c_direct = 1'b1;
			c_time = '1;
		end
		c_num = DW'(n);
		c_den = DW'(d);
	end

	// engine alternates phase and residual; each pass refreshes one target
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= ST_RGO;
			stg_q <= 1'b0;
			div_go_q <= 1'b0;
			num_q <= '0;
			den_q <= '0;
			ratio_q <= '0;
			t_new_q <= '0;
			tgt_q[0] <= '1;
			tgt_q[1] <= '1;
		end
		else
		begin
			div_go_q <= 1'b0;
			unique case (st_q)
				ST_RGO:
				begin
					// the log curve divides by k times the setting as well
					num_q <= (md == M_LOG) ? DW'(longint'(cur[stg_q]) * ONE_Q8 * K_SCALE)
						: DW'(longint'(cur[stg_q]) * ONE_Q8);
					den_q <= (md == M_LOG)
						? DW'(longint'(cfg_q[stg_q].k) * longint'(cfg_q[stg_q].set))
						: DW'(cfg_q[stg_q].set);
					div_go_q <= 1'b1;
					st_q <= ST_RWAIT;
				end
				ST_RWAIT:
					if (div_done)
					begin
						ratio_q <= (|div_quo[DW-1:16]) ? '1 : div_quo[15:0];
						st_q <= ST_TGO;
					end
				ST_TGO:
					if (c_direct)
					begin
						t_new_q <= c_time;
						st_q <= ST_STORE;
					end
					else
					begin
						num_q <= c_num;
						den_q <= c_den;
						div_go_q <= 1'b1;
						st_q <= ST_TWAIT;
					end
				ST_TWAIT:
					if (div_done)
					begin
						t_new_q <= (|div_quo[DW-1:32]) ? '1 : div_quo[31:0];
						st_q <= ST_STORE;
					end
				ST_STORE:
				begin
					tgt_q[stg_q] <= (t_new_q > ~PATH_DELAY_MS) ? '1
						: t_new_q + PATH_DELAY_MS;
					stg_q <= ~stg_q;
					st_q <= ST_RGO;
				end
				default: st_q <= ST_RGO;
			endcase
		end
	end

	itt_div #(
		.W(DW)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.go(div_go_q),
		.num(num_q),
		.den(den_q),
		.done(div_done),
		.quo(div_quo)
	);

	always_comb
	begin
		for (int s = 0; s < 2; s++)
			st_raw[s] = ({16'h0, cur[s]} << Q8) > 32'(cfg_q[s].set) * thr_of(mode_of(
				function_switch_group_q[(s == 0 ? PH_MODE_LSB : RES_MODE_LSB) +: 3]));
	end

	// elapsed time per stage; dropping below start clears it at once
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int s = 0; s < 2; s++)
			begin
				elapsed_q[s] <= '0;
				ind_q[s] <= '0;
			end
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (!st_raw[s])
					elapsed_q[s] <= '0;
				else if (tick_q && elapsed_q[s] != '1)
					elapsed_q[s] <= elapsed_q[s] + 1'b1;
				ind_q[s].start <= st_raw[s];
				ind_q[s].operate <= st_raw[s] && elapsed_q[s] >= tgt_q[s];
			end
		end
	end

	assign ev = {st_raw[1] && elapsed_q[1] >= tgt_q[1] && !ind_q[1].operate,
		st_raw[1] && !ind_q[1].start,
		st_raw[0] && elapsed_q[0] >= tgt_q[0] && !ind_q[0].operate,
		st_raw[0] && !ind_q[0].start};

	assign ph_start = ind_q[0].start;
	assign ph_operate = ind_q[0].operate;
	assign res_start = ind_q[1].start;
	assign res_operate = ind_q[1].operate;
endmodule

// >>> itt_top_sva.sv
module itt_top_sva
	import itt_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        ph_start,
	input wire logic        ph_operate,
	input wire logic        res_start,
	input wire logic        res_operate
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_answer;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence

	a_wr_resp_time: assert property (s_wr_taken |=> s_wr_answer)
		else $error("write response not two cycles after handshake");
	a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response not one cycle after handshake");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	a_ph_op_started: assert property (ph_operate |-> ph_start)
		else $error("phase operate without start");
	a_res_op_started: assert property (res_operate |-> res_start)
		else $error("residual operate without start");
	a_op_needs_time: assert property ($rose(ph_operate) |-> $past(ph_start, 2))
		else $error("phase operate rose without elapsed time");
	a_drop_clears: assert property ($fell(ph_start) |-> !ph_operate [*3])
		else $error("phase elapsed time not cleared on drop");
endmodule

bind itt_top itt_top_sva u_itt_top_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ph_start, .ph_operate,
	.res_start, .res_operate);

// >>> itt_meter.sv
module itt_meter
(
	input  wire logic        aclk,
	input  wire logic [15:0] ph_lvl,
	input  wire logic [15:0] res_lvl,
	output logic [15:0]      ph_current,
	output logic [15:0]      res_current
);
	timeunit 1ns;
	timeprecision 1ps;
	// front end delivers one sample per clock, so a step lands one edge late
	always @(posedge aclk)
	begin
		ph_current <= ph_lvl;
		res_current <= res_lvl;
	end
endmodule

// >>> itt_top_tb.sv
module itt_top_tb
	import itt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSC = 20;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
	logic [31:0] last_data;
	logic [15:0] ph_lvl = 16'h0, res_lvl = 16'h0, ph_current, res_current;
	logic ph_start, ph_operate, res_start, res_operate, irq;
	int miscompares = 0;
	int checks = 0;

	always #20 aclk = ~aclk;

	itt_meter u_itt_meter (.aclk, .ph_lvl, .res_lvl, .ph_current, .res_current);
	itt_top #(.MS_CYCLES(MSC)) u_itt_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ph_current, .res_current,
		.ph_start, .ph_operate, .res_start, .res_operate, .irq);

	task automatic give_verdict();
		$display("miscompares=%0d checks=%0d", miscompares, checks);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic fail_to(input string nm);
		miscompares++;
		$display("CHECK FAILED %s expected done seen timeout", nm);
		give_verdict();
	endtask

	task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic cmp_near(input string nm, input real ex, input real tol, input logic [31:0] got);
		real g;
		checks++;
		g = got;
		if ($isunknown(got) || g > ex + tol || g < ex - tol)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %0.1f seen %0d", nm, ex, got);
		end
	endtask

	// bready and rready rise only once the answer shows, so hold paths get exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready)
				break;
			if (s_axi_bvalid)
				s_axi_bready <= 1'h1;
		end
		last_resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (n == 100)
			fail_to("bvalid");
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (s_axi_rvalid)
				s_axi_rready <= 1'h1;
		end
		last_data = s_axi_rdata;
		last_resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (n == 100)
			fail_to("rvalid");
	endtask

	function automatic real exp_ms(input int m, input real x);
		real t;
		case (m)
			1: t = 80.0 / (x * x - 1.0);
			2: t = 13.5 / (x - 1.0);
			3: t = 0.14 / (x ** 0.02 - 1.0);
			4: t = 120.0 / (x - 1.0);
			5: t = 1.0 / (0.339 - 0.236 / x);
			default: t = 5.8 - 1.35 * $ln(x);
		endcase
		return t * 1000.0 + 30.0;
	endfunction

	task automatic t_reset_vals();
		rd(A_SWITCH);
		cmp("switch", 32'h0, last_data);
		rd(A_PH_SET);
		cmp("ph_set", 32'h100, last_data);
		rd(A_RES_K);
		cmp("res_k", 32'h3e8, last_data);
		rd(A_PH_DEF);
		cmp("ph_def", 32'h64, last_data);
		rd(8'h30);
		cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
		cmp("unmapped data", 32'h0, last_data);
		wr(8'h30, 32'h1);
		cmp("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, last_resp});
	endtask

	task automatic t_definite();
		int n;
		int c;
		logic [31:0] tgt;
		wr(A_PH_DEF, 32'h5);
		cmp("wr resp", {30'h0, RESP_OKAY}, {30'h0, last_resp});
		wr(A_RES_DEF, 32'h5);
		repeat (300) @(posedge aclk);
		rd(A_PH_TIME);
		tgt = last_data;
		cmp("ph def time", 32'h23, tgt);
		ph_lvl <= 16'h200;
		res_lvl <= 16'h200;
		for (n = 0; n < 10 && ph_start !== 1'h1; n++)
			@(posedge aclk);
		if (n == 10)
			fail_to("ph_start");
		for (c = 0; c < 5000 && ph_operate !== 1'h1; c++)
			@(posedge aclk);
		cmp_near("operate cycles", real'(tgt) * MSC, MSC + 4, c);
		repeat (2) @(posedge aclk);
		rd(A_STATUS);
		cmp("status", 32'hf, last_data);
		cmp("res operate", 32'h1, {31'h0, res_operate});
		cmp("irq masked", 32'h0, {31'h0, irq});
		wr(A_IRQ_MASK, 32'h2);
		repeat (3) @(posedge aclk);
		cmp("irq on", 32'h1, {31'h0, irq});
		wr(A_IRQ_ST, 32'hf);
		repeat (3) @(posedge aclk);
		cmp("irq cleared", 32'h0, {31'h0, irq});
		rd(A_IRQ_ST);
		cmp("irq status", 32'h0, last_data);
		ph_lvl <= 16'h0;
		repeat (4) @(posedge aclk);
		cmp("drop start", 32'h0, {31'h0, ph_start});
		ph_lvl <= 16'h200;
		repeat (6) @(posedge aclk);
		cmp("restart op", 32'h2, {30'h0, ph_start, ph_operate});
		ph_lvl <= 16'h0;
		res_lvl <= 16'h0;
	endtask

	task automatic t_thresholds();
		logic [2:0] tm [8] = '{3'h3, 3'h3, 3'h4, 3'h4, 3'h1, 3'h2, 3'h5, 3'h7};
		logic [15:0] tc [8] = '{16'h14d, 16'h14e, 16'h11a, 16'h11b, 16'h14e, 16'h14d,
			16'h101, 16'h100};
		logic [7:0] te = 8'h5a;
		for (int i = 0; i < 8; i++)
		begin
			wr(A_SWITCH, {29'h0, tm[i]});
			ph_lvl <= tc[i];
			repeat (4) @(posedge aclk);
			cmp("start level", {31'h0, te[i]}, {31'h0, ph_start});
			ph_lvl <= 16'h0;
			repeat (4) @(posedge aclk);
		end
	endtask

	task automatic t_curves();
		real e;
		for (int j = 0; j < 2; j++)
		begin
			for (int m = 1; m < 7; m++)
			begin
				wr(A_SWITCH, {24'h0, 3'(m), 2'h0, 3'(m)});
				ph_lvl <= (j == 0) ? 16'h400 : 16'h800;
				res_lvl <= (j == 0) ? 16'h400 : 16'h800;
				repeat (400) @(posedge aclk);
				e = exp_ms(m, (j == 0) ? 4.0 : 8.0);
				rd(A_PH_TIME);
				cmp_near("ph_time", e, e * 0.05, last_data);
				rd(A_RES_TIME);
				cmp_near("res_time", e, e * 0.05, last_data);
				cmp("res start", 32'h1, {31'h0, res_start});
			end
		end
		ph_lvl <= 16'h0;
		res_lvl <= 16'h0;
	endtask

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset_vals();
		t_definite();
		t_thresholds();
		t_curves();
		give_verdict();
	end
endmodule
